// [srls_pkg.sv]
// Constants, types and pin bundles for the flash read latency host
package srls_pkg;
    // Read opcodes, 3-byte and 4-byte address forms
    localparam logic [7:0] OPC_READ3 = 8'h03;
    localparam logic [7:0] OPC_READ4 = 8'h13;
    localparam logic [7:0] OPC_FAST3 = 8'h0b;
    localparam logic [7:0] OPC_FAST4 = 8'h0c;
    localparam logic [7:0] OPC_DOUT3 = 8'h3b;
    localparam logic [7:0] OPC_DOUT4 = 8'h3c;
    localparam logic [7:0] OPC_QOUT3 = 8'h6b;
    localparam logic [7:0] OPC_QOUT4 = 8'h6c;
    localparam logic [7:0] OPC_DIO3 = 8'hbb;
    localparam logic [7:0] OPC_DIO4 = 8'hbc;
    localparam logic [7:0] OPC_QIO3 = 8'heb;
    localparam logic [7:0] OPC_QIO4 = 8'hec;
    // Cycle count marking an unsupported command
    localparam logic [7:0] CYC_NONE = 8'hff;
    // Latency codes per clock band
    localparam logic [1:0] LC_50 = 2'h3;
    localparam logic [1:0] LC_80 = 2'h0;
    localparam logic [1:0] LC_90 = 2'h1;
    localparam logic [1:0] LC_104 = 2'h2;
    localparam logic [1:0] LC_133 = 2'h2;
    // Address widths in bits, bits per byte
    localparam logic [5:0] ADDR_BITS3 = 6'h18;
    localparam logic [5:0] ADDR_BITS4 = 6'h20;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // Serial clock half period in ref_clk cycles
    localparam int SCK_HALF_DEF = 2;
    // Output enables, active low; all high means released
    localparam logic [3:0] OEN_NONE = 4'hf;

    typedef enum logic [2:0] {
        K_NORMAL, K_FAST, K_DUALOUT, K_QUADOUT, K_DUALIO, K_QUADIO
    } srls_kind_e;
    typedef enum logic [2:0] {
        BAND_50, BAND_80, BAND_90, BAND_104, BAND_133
    } srls_band_e;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_CMD = 3'b001, S_ADDR = 3'b011, S_MODE = 3'b010,
        S_DUMMY = 3'b110, S_DATA = 3'b111, S_END = 3'b101
    } srls_state_e;

    typedef struct packed {
        logic [7:0] modeCyc;
        logic [7:0] latCyc;
    } srls_cyc_s;
    typedef struct packed {
        srls_kind_e kind;
        logic addr4;
        logic [31:0] addr;
    } srls_req_s;
    typedef struct packed {
        logic sck;
        logic csN;
        logic [3:0] ioOut;
        logic [3:0] ioOeN;
    } srls_pins_s;
    typedef struct packed {
        srls_state_e st;
        logic sck;
        logic csN;
        logic [7:0] div;
        logic [7:0] cnt;
        logic [7:0] falls;
        logic [31:0] sh;
        logic [2:0] wid;
        logic [2:0] dataW;
        srls_cyc_s cyc;
        logic [7:0] rd;
        logic [7:0] rdData;
        logic done;
        logic refused;
        logic [3:0] sync1;
        logic [3:0] sync2;
    } srls_st_s;

    localparam srls_st_s ST_RST = '{st: S_IDLE, sck: 1'b0, csN: 1'b1,
        div: 8'h00, cnt: 8'h00, falls: 8'h00, sh: 32'h0000_0000,
        wid: 3'h1, dataW: 3'h1, cyc: 16'h0000, rd: 8'h00, rdData: 8'h00,
        done: 1'b0, refused: 1'b0, sync1: 4'h0, sync2: 4'h0};
endpackage

// [srls_host.sv]
// Host that issues single-data-rate flash reads with per-band cycle counts
//
// Behaviour
// - Quad-output read opcode is 6Bh with 3-byte, 6Ch with 4-byte address.
// - Dual-I/O read opcode is BBh with 3-byte, BCh with 4-byte address.
// - Quad-I/O read opcode is EBh with 3-byte, ECh with 4-byte address.
// - Count FFh means unsupported; such a command is never issued.
// - 50 MHz, code 11b: normal, fast, dual and quad out use 0/0.
// - 50 MHz band: dual-I/O 4 mode 0 latency, quad-I/O 2 mode 1 latency.
// - 80 MHz, code 00b: normal unsupported; fast, dual, quad out 0/8.
// - 80 MHz band: dual-I/O 4 mode 0 latency, quad-I/O 2 mode 4 latency.
// - 90 MHz, code 01b: normal unsupported; fast, dual, quad out 0/8.
// - 90 MHz band: dual-I/O 4 mode 1 latency, quad-I/O 2 mode 4.
// - 104 MHz, code 10b: normal unsupported; fast 0/8; dual out 0 mode.
// - 104 MHz: dual, quad out 8 latency; dual-I/O 4/2; quad-I/O 2/5.
// - 133 MHz, code 10b: only fast read, 0 mode 8 latency cycles.
`timescale 1ns/1ps
module srls_host
    import srls_pkg::*;
#(
    parameter int SCK_HALF = SCK_HALF_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire srls_req_s req,
    input wire srls_band_e band,
    output logic [1:0] latencyCode,
    output logic busy,
    output logic done,
    output logic refused,
    output logic [7:0] rdData,
    output srls_pins_s pins,
    input wire logic [3:0] ioIn
);
    srls_st_s s;
    srls_st_s n;
    srls_cyc_s cyc;
    logic [7:0] opc;
    logic [2:0] addrW;
    logic [2:0] dataW;
    logic unsup;
    logic tick;
    logic fall;

    // Cycle table per band and read kind
    always_comb begin
        cyc = '{modeCyc: CYC_NONE, latCyc: CYC_NONE};
        case (band)
            BAND_50: begin
                latencyCode = LC_50;
                if (req.kind == K_DUALIO) cyc = '{8'h04, 8'h00};
                else if (req.kind == K_QUADIO) cyc = '{8'h02, 8'h01};
                else cyc = '{8'h00, 8'h00};
            end
            BAND_80: begin
                latencyCode = LC_80;
                if (req.kind == K_DUALIO) cyc = '{8'h04, 8'h00};
                else if (req.kind == K_QUADIO) cyc = '{8'h02, 8'h04};
                else if (req.kind != K_NORMAL) cyc = '{8'h00, 8'h08};
            end
            BAND_90: begin
                latencyCode = LC_90;
                if (req.kind == K_DUALIO) cyc = '{8'h04, 8'h01};
                else if (req.kind == K_QUADIO) cyc = '{8'h02, 8'h04};
                else if (req.kind != K_NORMAL) cyc = '{8'h00, 8'h08};
            end
            BAND_104: begin
                latencyCode = LC_104;
                if (req.kind == K_DUALIO) cyc = '{8'h04, 8'h02};
                else if (req.kind == K_QUADIO) cyc = '{8'h02, 8'h05};
                else if (req.kind != K_NORMAL) cyc = '{8'h00, 8'h08};
            end
            BAND_133: begin
                latencyCode = LC_133;
                if (req.kind == K_FAST) cyc = '{8'h00, 8'h08};
            end
            default: latencyCode = LC_50;
        endcase
    end

    // Opcode and line widths per kind
    always_comb begin
        case (req.kind)
            K_NORMAL: opc = req.addr4 ? OPC_READ4 : OPC_READ3;
            K_FAST: opc = req.addr4 ? OPC_FAST4 : OPC_FAST3;
            K_DUALOUT: opc = req.addr4 ? OPC_DOUT4 : OPC_DOUT3;
            K_QUADOUT: opc = req.addr4 ? OPC_QOUT4 : OPC_QOUT3;
            K_DUALIO: opc = req.addr4 ? OPC_DIO4 : OPC_DIO3;
            K_QUADIO: opc = req.addr4 ? OPC_QIO4 : OPC_QIO3;
            default: opc = OPC_READ3;
        endcase
        addrW = (req.kind == K_DUALIO) ? 3'h2 :
                (req.kind == K_QUADIO) ? 3'h4 : 3'h1;
        dataW = (req.kind == K_DUALOUT || req.kind == K_DUALIO) ? 3'h2 :
                (req.kind == K_QUADOUT || req.kind == K_QUADIO) ? 3'h4 : 3'h1;
        unsup = (cyc.modeCyc == CYC_NONE) || (cyc.latCyc == CYC_NONE);
    end

    // Pick the phase after address or mode; zero-length phases are skipped
    function automatic srls_st_s nextPhase(srls_st_s x, logic fromMode);
        srls_st_s y;
        y = x;
        y.falls = 8'h00;
        y.sh = 32'h0000_0000; // Mode bits all zero, no continuous read
        if (!fromMode && x.cyc.modeCyc != 8'h00) begin
            y.st = S_MODE;
            y.cnt = x.cyc.modeCyc - 8'h01;
        end else if (x.cyc.latCyc != 8'h00) begin
            y.st = S_DUMMY;
            y.cnt = x.cyc.latCyc - 8'h01;
        end else begin
            y.st = S_DATA;
            y.cnt = 8'(BYTE_BITS / x.dataW) - 8'h01;
        end
        return y;
    endfunction

    // Serial clock divider edges
    assign tick = (s.div == 8'(SCK_HALF - 1));
    assign fall = tick && s.sck;

    // Next state: one sequencer walks opcode, address, mode, dummy, data
    always_comb begin
        n = s;
        n.done = 1'b0;
        n.refused = 1'b0;
        n.sync1 = ioIn;
        n.sync2 = s.sync1;
        if (s.st != S_IDLE && s.st != S_END) begin
            n.div = tick ? 8'h00 : s.div + 8'h01;
            if (tick) n.sck = ~s.sck;
            if (fall) n.falls = s.falls + 8'h01;
        end
        case (s.st)
            S_IDLE: begin
                if (start && unsup) begin
                    n.refused = 1'b1;
                end else if (start) begin
                    n.st = S_CMD;
                    n.csN = 1'b0;
                    n.div = 8'h00;
                    n.sck = 1'b0;
                    n.sh = {opc, 24'h00_0000};
                    n.wid = 3'h1;
                    n.cnt = 8'(BYTE_BITS) - 8'h01;
                    n.cyc = cyc;
                    n.dataW = dataW;
                    n.falls = 8'h00;
                end
            end
            S_CMD: if (fall) begin
                if (s.cnt != 8'h00) begin
                    n.sh = s.sh << s.wid;
                    n.cnt = s.cnt - 8'h01;
                end else begin
                    n.st = S_ADDR;
                    n.falls = 8'h00;
                    n.wid = addrW;
                    n.sh = req.addr4 ? req.addr : {req.addr[23:0], 8'h00};
                    n.cnt = 8'((req.addr4 ? ADDR_BITS4 : ADDR_BITS3) / addrW)
                            - 8'h01;
                end
            end
            S_ADDR: if (fall) begin
                if (s.cnt != 8'h00) begin
                    n.sh = s.sh << s.wid;
                    n.cnt = s.cnt - 8'h01;
                end else begin
                    n = nextPhase(n, 1'b0);
                end
            end
            S_MODE, S_DUMMY: if (fall) begin
                if (s.cnt != 8'h00) n.cnt = s.cnt - 8'h01;
                else if (s.st == S_MODE) n = nextPhase(n, 1'b1);
                else begin
                    n.st = S_DATA;
                    n.falls = 8'h00;
                    n.cnt = 8'(BYTE_BITS / s.dataW) - 8'h01;
                end
            end
            S_DATA: if (fall) begin
                // Sampled late in the high phase through the synchroniser
                case (s.dataW)
                    3'h4: n.rd = {s.rd[3:0], s.sync2};
                    3'h2: n.rd = {s.rd[5:0], s.sync2[1:0]};
                    default: n.rd = {s.rd[6:0], s.sync2[1]};
                endcase
                n.cnt = s.cnt - 8'h01;
                if (s.cnt == 8'h00) begin
                    n.st = S_END;
                    n.csN = 1'b1;
                    n.done = 1'b1;
                    n.rdData = n.rd;
                end
            end
            S_END: n.st = S_IDLE; // Guarantees one idle cycle of chip select
            default: n = ST_RST;
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) s <= ST_RST;
        else s <= n;
    end

    // Pins: drive only the lines in use during opcode, address and mode
    always_comb begin
        pins.sck = s.sck;
        pins.csN = s.csN;
        pins.ioOut = 4'h0;
        pins.ioOeN = OEN_NONE;
        if (s.st == S_CMD || s.st == S_ADDR || s.st == S_MODE) begin
            case (s.wid)
                3'h4: begin
                    pins.ioOut = s.sh[31:28];
                    pins.ioOeN = 4'h0;
                end
                3'h2: begin
                    pins.ioOut = {2'h0, s.sh[31:30]};
                    pins.ioOeN = 4'hc;
                end
                default: begin
                    pins.ioOut = {3'h0, s.sh[31]};
                    pins.ioOeN = 4'he;
                end
            endcase
        end
    end

    assign busy = (s.st != S_IDLE);
    assign done = s.done;
    assign refused = s.refused;
    assign rdData = s.rdData;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence goodStart;
        s.st == S_IDLE && start && !unsup;
    endsequence
    sequence phaseEnd(srls_state_e p);
        s.st == p && fall && s.cnt == 8'h00;
    endsequence

    opc_quad_out_a: assert property (goodStart ##0 req.kind == K_QUADOUT |=>
        s.sh[31:24] == ($past(req.addr4) ? 8'h6c : 8'h6b))
        else $error("quad output opcode wrong");
    opc_dual_io_a: assert property (goodStart ##0 req.kind == K_DUALIO |=>
        s.sh[31:24] == ($past(req.addr4) ? 8'hbc : 8'hbb))
        else $error("dual io opcode wrong");
    opc_quad_io_a: assert property (goodStart ##0 req.kind == K_QUADIO |=>
        s.sh[31:24] == ($past(req.addr4) ? 8'hec : 8'heb))
        else $error("quad io opcode wrong");
    unsup_refuse_a: assert property (s.st == S_IDLE && start && unsup |=>
        refused && s.st == S_IDLE && pins.csN ##1 !refused)
        else $error("unsupported read was issued");
    band50_zero_a: assert property (goodStart ##0 band == BAND_50 &&
        req.kind < K_DUALIO |=> s.cyc == 16'h0000)
        else $error("50 MHz band cycles not zero");
    band80_fast_a: assert property (goodStart ##0 band == BAND_80 &&
        req.kind == K_FAST |=> s.cyc == 16'h0008 && latencyCode == 2'h0)
        else $error("80 MHz fast read cycles wrong");
    band104_qio_a: assert property (goodStart ##0 band == BAND_104 &&
        req.kind == K_QUADIO |=> s.cyc == 16'h0205)
        else $error("104 MHz quad io cycles wrong");
    band133_only_a: assert property (s.st == S_IDLE && start &&
        band == BAND_133 && req.kind != K_FAST |=> refused)
        else $error("133 MHz non-fast read not refused");
    mode_count_a: assert property (phaseEnd(S_MODE) |->
        s.falls + 8'h01 == s.cyc.modeCyc)
        else $error("mode cycle count wrong");
    dummy_count_a: assert property (phaseEnd(S_DUMMY) |=>
        s.st == S_DATA && $past(s.falls) + 8'h01 == s.cyc.latCyc &&
        pins.ioOeN == 4'hf)
        else $error("latency cycle count wrong");
    read_done_a: assert property (phaseEnd(S_DATA) |=>
        done && pins.csN ##1 !done && !busy)
        else $error("read did not end cleanly");
endmodule

// [srls_flash_model.sv]
// Behavioural flash device answering single-data-rate reads
`timescale 1ns/1ps
module srls_flash_model
    import srls_pkg::*;
#(
    parameter logic [7:0] QOUT104_MODE = 8'h00
) (
    input wire logic sck,
    input wire logic csN,
    input wire logic [3:0] io,
    input wire logic [1:0] latCode,
    output logic [3:0] devOut,
    output int frames,
    output logic [7:0] lastOpc,
    output logic [31:0] lastAddr
);
    // Mode and latency counts per code, index is the read kind
    function automatic logic [15:0] cycles(input logic [1:0] c, input int k);
        logic [5:0][15:0] t;
        case (c)
            2'h3: t = {16'h0201, 16'h0400, 16'h0000, 16'h0000, 16'h0000,
                16'h0000};
            2'h0: t = {16'h0204, 16'h0400, 16'h0008, 16'h0008, 16'h0008,
                16'hffff};
            2'h1: t = {16'h0204, 16'h0401, 16'h0008, 16'h0008, 16'h0008,
                16'hffff};
            // Code 10b also serves the top band; fast read counts agree
            default: t = {16'h0205, 16'h0402, QOUT104_MODE, 8'h08, 16'h0008,
                16'h0008, 16'hffff};
        endcase
        return t[k];
    endfunction

    // One frame: opcode, address, mode, latency, then one data byte
    task automatic frame();
        logic [7:0] opc;
        logic [7:0] dat;
        logic [31:0] ad;
        logic [15:0] cy;
        int k;
        int aw;
        int dw;
        int i;
        for (i = 0; i < 8; i++) begin
            @(posedge sck);
            opc = {opc[6:0], io[0]};
        end
        lastOpc = opc;
        case (opc)
            8'h03, 8'h13: k = 0;
            8'h0b, 8'h0c: k = 1;
            8'h3b, 8'h3c: k = 2;
            8'h6b, 8'h6c: k = 3;
            8'hbb, 8'hbc: k = 4;
            8'heb, 8'hec: k = 5;
            default: return;
        endcase
        aw = (k == 4) ? 2 : (k == 5) ? 4 : 1;
        dw = (k < 2) ? 1 : (k == 2 || k == 4) ? 2 : 4;
        cy = cycles(latCode, k);
        if (cy[15:8] == 8'hff) begin
            return;
        end
        ad = 32'h0000_0000;
        for (i = 0; i < ((opc == 8'h13 || opc[3:0] == 4'hc) ? 32 : 24) / aw;
            i++) begin
            @(posedge sck);
            ad = (ad << aw) | 32'(io & ((4'h1 << aw) - 4'h1));
        end
        lastAddr = ad;
        // Mode bits sampled and dropped, latency clocks ignored
        repeat (int'(cy[15:8]) + int'(cy[7:0])) @(posedge sck);
        dat = opc ^ ad[7:0];
        for (i = 0; i < 8 / dw; i++) begin
            @(negedge sck);
            case (dw)
                1: devOut = {~devOut[3:2], dat[7], ~devOut[0]};
                2: devOut = {~devOut[3:2], dat[7:6]};
                default: devOut = dat[7:4];
            endcase
            dat = dat << dw;
        end
    endtask

    // Frame runner; a rising select aborts whatever is under way
    initial begin
        devOut = 4'h5;
        frames = 0;
        lastOpc = 8'h00;
        lastAddr = 32'h0000_0000;
        forever begin
            @(negedge csN);
            frames++;
            fork
                frame();
                @(posedge csN);
            join_any
            disable fork;
            wait (csN === 1'b1);
            // Released lines must not keep the last level
            devOut = ~devOut;
        end
    end
endmodule

// [spi_read_latency_selection_tb.sv]
// Self-checking bench for the flash read latency host
`timescale 1ns/1ps
module spi_read_latency_selection_tb;
    import srls_pkg::*;
    localparam logic [7:0] OPCS [12] = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b,
        8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    srls_req_s req = '0;
    srls_band_e band = BAND_50;
    logic [1:0] latencyCode;
    logic busy;
    logic done;
    logic refused;
    logic [7:0] rdData;
    srls_pins_s pins;
    logic [3:0] devOut;
    logic [3:0] io;
    int frames;
    logic [7:0] lastOpc;
    logic [31:0] lastAddr;
    int errTotal = 0;
    int totalChecks = 0;

    // Clock and wire resolution of the four data lines
    always #20 ref_clk = ~ref_clk;
    assign io = (pins.ioOeN & devOut) | (~pins.ioOeN & pins.ioOut);

    srls_host #(.SCK_HALF(2)) srls_host_inst (.ref_clk(ref_clk), .rst(rst),
        .start(start), .req(req), .band(band), .latencyCode(latencyCode),
        .busy(busy), .done(done), .refused(refused), .rdData(rdData),
        .pins(pins), .ioIn(io));
    // Device is programmed with the code the host reports
    srls_flash_model srls_flash_model_inst (.sck(pins.sck), .csN(pins.csN),
        .io(io), .latCode(latencyCode), .devOut(devOut), .frames(frames),
        .lastOpc(lastOpc), .lastAddr(lastAddr));

    task automatic conclude();
        if (errTotal == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkf(input logic got, input logic exp);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // Bounded wait for completion, or for idle when idle is set
    task automatic waitFor(input logic idle);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while ((idle ? busy !== 1'b0 : (done !== 1'b1 &&
            refused !== 1'b1)) && n < 3000);
        if (n >= 3000) begin
            errTotal++;
            $display("mismatch at %0t: wait ran out", $time);
            conclude();
        end
    endtask

    task automatic checkIdle();
        @(negedge ref_clk);
        chkf(pins.csN, 1'b1);
        chkf(pins.sck, 1'b0);
        chkv(32'(pins.ioOeN), 32'h0000_000f);
        chkf(busy, 1'b0);
        // Reset also clears the one-cycle flags and the read byte
        chkf(done, 1'b0);
        chkf(refused, 1'b0);
        chkv(32'(rdData), 32'h0000_0000);
    endtask

    // One read; no says the table forbids it in this band
    task automatic doRead(input int k, input logic a4, input logic [31:0] ad,
        input logic no);
        int f0;
        logic [7:0] opc;
        opc = OPCS[2 * k + int'(a4)];
        f0 = frames;
        @(posedge ref_clk);
        req <= '{kind: srls_kind_e'(k[2:0]), addr4: a4, addr: ad};
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        waitFor(1'b0);
        chkf(refused, no);
        chkf(done, ~no);
        chkv(32'(frames), 32'(no ? f0 : f0 + 1));
        if (!no) begin
            chkv(32'(lastOpc), 32'(opc));
            chkv(lastAddr, a4 ? ad : {8'h00, ad[23:0]});
            chkv(32'(rdData), 32'(opc ^ ad[7:0]));
        end
        waitFor(1'b1);
    endtask

    // Every kind in both address forms, back to back, in one band
    task automatic scenBand(input srls_band_e b, input logic [1:0] code,
        input logic [5:0] no);
        @(posedge ref_clk);
        band <= b;
        @(negedge ref_clk);
        chkv(32'(latencyCode), 32'(code));
        for (int k = 0; k < 6; k++) begin
            for (int a = 0; a < 2; a++) begin
                doRead(k, 1'(a), 32'h8d3c_a170 + 32'(k * 37 + a * 5), no[k]);
            end
        end
    endtask

    // Start kept high for the first 40 cycles of a frame gives one frame only
    task automatic scenBusy();
        int f0;
        f0 = frames;
        @(posedge ref_clk);
        band <= BAND_104;
        req <= '{kind: K_QUADIO, addr4: 1'b1, addr: 32'h0f1e_2d3c};
        start <= 1'b1;
        repeat (40) @(posedge ref_clk);
        start <= 1'b0;
        waitFor(1'b0);
        chkv(32'(rdData), 32'(8'hec ^ 8'h3c));
        repeat (20) @(negedge ref_clk);
        chkv(32'(frames), 32'(f0 + 1));
        chkf(busy, 1'b0);
    endtask

    // Reset in mid-frame releases the pins, then reads work again
    task automatic scenReset();
        @(posedge ref_clk);
        req <= '{kind: K_FAST, addr4: 1'b0, addr: 32'h0000_1234};
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        repeat (30) @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        checkIdle();
        doRead(1, 1'b1, 32'h7e81_c3a5, 1'b0);
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        checkIdle();
        scenBand(BAND_50, 2'h3, 6'h00);
        scenBand(BAND_80, 2'h0, 6'h01);
        scenBand(BAND_90, 2'h1, 6'h01);
        scenBand(BAND_104, 2'h2, 6'h01);
        scenBand(BAND_133, 2'h2, 6'h3d);
        scenBusy();
        scenReset();
        conclude();
    end
endmodule
